// ---- rtl/mcu4_alu_transfer_io_decode.sv ----
`timescale 1ns/10ps
`include "mcu4_cfg.svh"
module mcu4_alu_transfer_io_decode
	import mcu4_pkg::*;
(
	input  wire logic        clock_i,
	input  wire logic        rst_i,
	input  wire logic        exec_i,
	input  wire logic [15:0] instr_i,
	input  wire logic [2:0]  row_pointer_i,
	input  wire logic [3:0]  port_in_i,
	output logic             carry_o,
	output logic             skip_o,
	output logic             port_req_o,
	output logic             port_dir_out_o,
	output logic [2:0]       port_group_o,
	output logic [2:0]       port_code_o,
	output logic [3:0]       port_data_o
);
	logic [3:0]  mem_reg [0:127];
	state_type   state_reg;
	state_type   state_next;
	instr_type   ins;
	logic [3:0]  m_val;
	logic [3:0]  g_val;
	logic [3:0]  x_val;
	logic [6:0]  m_addr;
	logic [6:0]  g_addr;
	logic [6:0]  x_addr;
	logic [6:0]  w_addr;
	logic [3:0]  w_data;
	logic        w_en;
	logic [4:0]  sum;
	logic        cmp_hit;
	logic [3:0]  cmp_a;
	logic [3:0]  cmp_b;

	assign ins    = instr_type'(instr_i);
	assign m_addr = {1'h0, ins.row_field, ins.column_field};
	assign g_addr = {3'h0, ins.operand};
	assign m_val  = mem_reg[m_addr];
	assign g_val  = mem_reg[g_addr];

	// indexed address
	// kept out of the main process so the indexed read forms no loop
	always_comb begin
		x_addr = {1'h0, ins.row_field, g_val};
		if (ins.opcode_field == `OP_ROW_LOCAL_COPY)
			x_addr = {1'h0, ins.row_field, ins.operand};
		else if (ins.opcode_field == `OP_GREG_ROW_DEST
				|| ins.opcode_field == `OP_GREG_ROW_SRC)
			x_addr = {row_pointer_i, g_val};
	end

	always_comb begin
		state_next = state_reg;
		state_next.skip = 1'h0;
		state_next.port.valid = 1'h0;
		w_en    = 1'h0;
		w_addr  = m_addr;
		w_data  = m_val;
		sum     = 5'h00;
		cmp_hit = 1'h0;
		cmp_a   = m_val;
		cmp_b   = ins.operand;
		if (exec_i) begin
			unique case (ins.opcode_field)
			`OP_IMM_PLUS, `OP_IMM_PLUS_SKIP_C, `OP_IMM_PLUS_SKIP_NC,
			`OP_IMM_PLUS_CY, `OP_IMM_PLUS_CY_SKIP_C, `OP_IMM_PLUS_CY_SKIP_NC: begin
				// five-bit sum, top bit is carry
				sum = {1'h0, m_val} + {1'h0, ins.operand}
					+ {4'h0, ins.opcode_field[3] & state_reg.carry};
				w_en = 1'h1;
				w_data = sum[3:0];
			end
			`OP_IMM_MINUS, `OP_IMM_MINUS_SKIP_B, `OP_IMM_MINUS_SKIP_NB,
			`OP_IMM_MINUS_BW, `OP_IMM_MINUS_BW_SKIP_B, `OP_IMM_MINUS_BW_SKIP_NB: begin
				sum = {1'h0, m_val} - {1'h0, ins.operand}
					- {4'h0, ins.opcode_field[3] & state_reg.carry};
				w_en = 1'h1;
				w_data = sum[3:0];
			end
			`OP_GR_PLUS_MEM, `OP_GR_PLUS_MEM_SKIP_C, `OP_GR_PLUS_MEM_SKIP_NC,
			`OP_GR_PLUS_MEM_CY, `OP_GR_PLUS_MEM_CY_SKIP_C, `OP_GR_PLUS_MEM_CY_SKIP_NC: begin
				sum = {1'h0, g_val} + {1'h0, m_val}
					+ {4'h0, ins.opcode_field[3] & state_reg.carry};
				w_en = 1'h1;
				w_addr = g_addr;
				w_data = sum[3:0];
			end
			`OP_GR_MINUS_MEM, `OP_GR_MINUS_MEM_SKIP_B, `OP_GR_MINUS_MEM_SKIP_NB,
			`OP_GR_MINUS_MEM_BW, `OP_GR_MINUS_MEM_BW_SKIP_B,
			`OP_GR_MINUS_MEM_BW_SKIP_NB: begin
				sum = {1'h0, g_val} - {1'h0, m_val}
					- {4'h0, ins.opcode_field[3] & state_reg.carry};
				w_en = 1'h1;
				w_addr = g_addr;
				w_data = sum[3:0];
			end
			`OP_MEM_TO_GR_GET: begin
				w_en = 1'h1;
				w_addr = g_addr;
			end
			`OP_GR_TO_MEM_PUT: begin
				w_en = 1'h1;
				w_data = g_val;
			end
			`OP_GR_INDEXED_DEST: begin
				w_en = 1'h1;
				w_addr = x_addr;
			end
			`OP_GR_INDEXED_SRC: begin
				w_en = 1'h1;
				w_data = x_val;
			end
			`OP_ROW_LOCAL_COPY: begin
				w_en = 1'h1;
				w_data = x_val;
			end
			`OP_IMM_TO_MEM_COPY: begin
				w_en = 1'h1;
				w_data = ins.operand;
			end
			`OP_GREG_ROW_DEST: begin
				w_en = 1'h1;
				w_addr = x_addr;
			end
			`OP_GREG_ROW_SRC: begin
				w_en = 1'h1;
				w_data = x_val;
			end
			`OP_PLL_XFER, `OP_DISPLAY_XFER, `OP_INDICATOR_XFER, `OP_GENERAL_XFER,
			`OP_KEY_XFER, `OP_SERIAL_XFER: begin
				state_next.port.valid = 1'h1;
				state_next.port.is_output = ins.operand[3];
				state_next.port.group = 3'(ins.opcode_field - `OP_PLL_XFER);
				state_next.port.port_code_low3 = ins.operand[2:0];
				state_next.port.data = m_val;
				// serial direction same as other ports
				if (!ins.operand[3]) begin
					w_en = 1'h1;
					w_data = port_in_i;
				end
			end
			6'h30, 6'h31, 6'h32, 6'h33, 6'h34, 6'h35, 6'h36, 6'h37: begin
				if (ins.opcode_field[2]) begin
					cmp_a = g_val;
					cmp_b = m_val;
				end
				unique case (ins.opcode_field[1:0])
				2'h0: cmp_hit = cmp_a < cmp_b;
				2'h1: cmp_hit = cmp_a >= cmp_b;
				2'h2: cmp_hit = cmp_a == cmp_b;
				2'h3: cmp_hit = cmp_a != cmp_b;
				endcase
				sum = {cmp_a < cmp_b, 4'h0};
			end
			default: begin
				sum = 5'h00;
			end
			endcase
			state_next.carry = sum[4];
			if (ins.opcode_field[5:4] == 2'h3)
				state_next.skip = cmp_hit;
			// slots 6 and 7 of the low groups only clear carry here and must never skip
			else if (ins.opcode_field[5] == 1'h0 && (ins.opcode_field[2:0] == 3'h1
					|| ins.opcode_field[2:0] == 3'h2 || ins.opcode_field[2:0] == 3'h4
					|| ins.opcode_field[2:0] == 3'h5))
				state_next.skip = (ins.opcode_field[2:0] == 3'h1 || ins.opcode_field[2:0] == 3'h4)
					? sum[4] : ~sum[4];
		end
	end
	assign x_val = mem_reg[x_addr];

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			state_reg <= '0;
			state_reg.carry <= `RESET_CARRY;
		end else begin
			state_reg <= state_next;
		end
		if (w_en && !rst_i)
			mem_reg[w_addr] <= w_data;
	end

	assign carry_o        = state_reg.carry;
	assign skip_o         = state_reg.skip;
	assign port_req_o     = state_reg.port.valid;
	assign port_dir_out_o = state_reg.port.is_output;
	assign port_group_o   = state_reg.port.group;
	assign port_code_o    = state_reg.port.port_code_low3;
	assign port_data_o    = state_reg.port.data;

	a_skip_on_carry: assert property (@(posedge clock_i) disable iff (rst_i)
		exec_i && instr_i[15:10] == `OP_IMM_PLUS_SKIP_C |=> skip_o == carry_o)
		else $error("skip on carry mismatch");
	a_skip_no_carry: assert property (@(posedge clock_i) disable iff (rst_i)
		exec_i && instr_i[15:10] == `OP_GR_PLUS_MEM_SKIP_NC |=> skip_o != carry_o)
		else $error("skip on no carry mismatch");
	a_plain_no_skip: assert property (@(posedge clock_i) disable iff (rst_i)
		exec_i && instr_i[15:10] == `OP_IMM_PLUS_CY |=> !skip_o)
		else $error("plain add skipped");
	a_idle_no_req: assert property (@(posedge clock_i) disable iff (rst_i)
		!exec_i |=> !port_req_o && !skip_o)
		else $error("request without instruction");
	a_port_dir_msb: assert property (@(posedge clock_i) disable iff (rst_i)
		exec_i && instr_i[15:10] == `OP_GENERAL_XFER |=> port_req_o
		&& port_dir_out_o == $past(instr_i[3]) && port_group_o == 3'h3)
		else $error("port direction wrong");
	a_cmp_equal: assert property (@(posedge clock_i) disable iff (rst_i)
		exec_i && instr_i[15:10] == 6'h32 && m_val == instr_i[3:0] |=> skip_o && !carry_o)
		else $error("equal compare no skip");
	a_move_no_carry: assert property (@(posedge clock_i) disable iff (rst_i)
		exec_i && instr_i[15:10] == `OP_IMM_TO_MEM_COPY |=> !carry_o)
		else $error("move left carry set");
	a_wrap_carry: assert property (@(posedge clock_i) disable iff (rst_i)
		exec_i && instr_i[15:10] == `OP_IMM_PLUS && m_val == 4'hF && instr_i[3:0] == 4'h1
		|=> carry_o)
		else $error("no carry on wrap");
	a_undef_no_skip: assert property (@(posedge clock_i) disable iff (rst_i)
		exec_i && !instr_i[15] && instr_i[12:11] == 2'h3 |=> !skip_o && !carry_o)
		else $error("undecoded code skipped or set carry");
endmodule // mcu4_alu_transfer_io_decode

// ---- common/mcu4_cfg.svh ----
`ifndef MCU4_CFG_SVH
`define MCU4_CFG_SVH
`define OP_IMM_PLUS            6'h00
`define OP_IMM_PLUS_SKIP_C     6'h01
`define OP_IMM_PLUS_SKIP_NC    6'h02
`define OP_IMM_MINUS           6'h03
`define OP_IMM_MINUS_SKIP_B    6'h04
`define OP_IMM_MINUS_SKIP_NB   6'h05
`define OP_IMM_PLUS_CY         6'h08
`define OP_IMM_PLUS_CY_SKIP_C  6'h09
`define OP_IMM_PLUS_CY_SKIP_NC 6'h0A
`define OP_IMM_MINUS_BW        6'h0B
`define OP_IMM_MINUS_BW_SKIP_B 6'h0C
`define OP_IMM_MINUS_BW_SKIP_NB 6'h0D
`define OP_GR_PLUS_MEM         6'h10
`define OP_GR_PLUS_MEM_SKIP_C  6'h11
`define OP_GR_PLUS_MEM_SKIP_NC 6'h12
`define OP_GR_MINUS_MEM        6'h13
`define OP_GR_MINUS_MEM_SKIP_B 6'h14
`define OP_GR_MINUS_MEM_SKIP_NB 6'h15
`define OP_GR_PLUS_MEM_CY      6'h18
`define OP_GR_PLUS_MEM_CY_SKIP_C 6'h19
`define OP_GR_PLUS_MEM_CY_SKIP_NC 6'h1A
`define OP_GR_MINUS_MEM_BW     6'h1B
`define OP_GR_MINUS_MEM_BW_SKIP_B 6'h1C
`define OP_GR_MINUS_MEM_BW_SKIP_NB 6'h1D
`define OP_MEM_TO_GR_GET       6'h20
`define OP_GR_TO_MEM_PUT       6'h21
`define OP_GR_INDEXED_DEST     6'h22
`define OP_GR_INDEXED_SRC      6'h23
`define OP_ROW_LOCAL_COPY      6'h24
`define OP_IMM_TO_MEM_COPY     6'h25
`define OP_GREG_ROW_DEST       6'h26
`define OP_GREG_ROW_SRC        6'h27
`define OP_PLL_XFER            6'h28
`define OP_DISPLAY_XFER        6'h29
`define OP_INDICATOR_XFER      6'h2A
`define OP_GENERAL_XFER        6'h2B
`define OP_KEY_XFER            6'h2C
`define OP_SERIAL_XFER         6'h2D
`define OP_CMP_IMM_BASE        6'h30
`define OP_CMP_GR_BASE         6'h34
`define RESET_CARRY            1'h0
`endif

// ---- common/mcu4_pkg.sv ----
package mcu4_pkg;
	typedef struct packed {
		logic [5:0] opcode_field;
		logic [1:0] row_field;
		logic [3:0] column_field;
		logic [3:0] operand;
	} instr_type;
	typedef struct packed {
		logic       valid;
		logic       is_output;
		logic [2:0] group;
		logic [2:0] port_code_low3;
		logic [3:0] data;
	} port_req_type;
	typedef struct packed {
		logic         carry;
		logic         skip;
		port_req_type port;
	} state_type;
endpackage

// ---- dv/test_mcu4_alu_transfer_io_decode.sv ----
`timescale 1ns/10ps
module test_mcu4_alu_transfer_io_decode;
	logic        clock_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        exec_i = 1'b0;
	logic [15:0] instr_i = 16'h0000;
	logic [2:0]  row_pointer_i = 3'h0;
	logic [3:0]  port_in_i = 4'h0;
	logic        carry_o;
	logic        skip_o;
	logic        port_req_o;
	logic        port_dir_out_o;
	logic [2:0]  port_group_o;
	logic [2:0]  port_code_o;
	logic [3:0]  port_data_o;
	int          bad_count = 0;
	int          tests_run = 0;
	// immediate chain on one word: opcode, operand, carry and skip per step
	logic [5:0]  iop [13] = '{6'h00, 6'h01, 6'h02, 6'h01, 6'h08, 6'h0A, 6'h09,
		6'h03, 6'h0C, 6'h04, 6'h0B, 6'h0D, 6'h05};
	logic [3:0]  iimm [13] = '{4'h3, 4'hF, 4'h4, 4'hC, 4'h2, 4'hD, 4'h0,
		4'h2, 4'hE, 4'h1, 4'h3, 4'h1, 4'hB};
	logic [12:0] icy = 13'b1101010101001;
	logic [12:0] isk = 13'b0111000001010;
	logic [5:0]  gop [11] = '{6'h11, 6'h19, 6'h12, 6'h1A, 6'h18, 6'h14, 6'h1C,
		6'h1B, 6'h1D, 6'h13, 6'h15};
	logic [10:0] gcy = 11'b10110011011;
	logic [10:0] gsk = 11'b10000010100;

	always #12.5 clock_i = ~clock_i;

	mcu4_alu_transfer_io_decode dut_u (
		.clock_i        (clock_i),
		.rst_i          (rst_i),
		.exec_i         (exec_i),
		.instr_i        (instr_i),
		.row_pointer_i  (row_pointer_i),
		.port_in_i      (port_in_i),
		.carry_o        (carry_o),
		.skip_o         (skip_o),
		.port_req_o     (port_req_o),
		.port_dir_out_o (port_dir_out_o),
		.port_group_o   (port_group_o),
		.port_code_o    (port_code_o),
		.port_data_o    (port_data_o)
	);

	task automatic cmp_bit(input logic got, input logic exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH %0t flag got %b exp %b", $time, got, exp);
		end
	endtask

	task automatic cmp_nib(input logic [3:0] got, input logic [3:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH %0t value got %h exp %h", $time, got, exp);
		end
	endtask

	// one pulse per instruction; results are settled at the next falling edge
	task automatic run(input logic [5:0] op, input logic [1:0] row, input logic [3:0] col,
		input logic [3:0] opd);
		@(negedge clock_i);
		exec_i = 1'b1;
		instr_i = {op, row, col, opd};
		@(negedge clock_i);
		exec_i = 1'b0;
	endtask

	// memory is only visible on port_data_o through a port transfer; read here with an output transfer on the general port, code 3
	task automatic rd(input logic [1:0] row, input logic [3:0] col, input logic [3:0] exp);
		run(6'h2B, row, col, 4'hB);
		cmp_bit(port_req_o, 1'b1);
		cmp_bit(port_dir_out_o, 1'b1);
		cmp_nib(port_data_o, exp);
	endtask

	task automatic cmps(input logic [5:0] base, input logic [3:0] opd, input logic [3:0] a,
		input logic [3:0] b);
		logic [3:0] sk;
		sk = {a != b, a == b, a >= b, a < b};
		for (int k = 0; k < 4; k++) begin
			run(base + 6'(k), 2'h2, 4'h3, opd);
			cmp_bit(skip_o, sk[k]);
			cmp_bit(carry_o, a < b);
		end
	endtask

	task automatic t_imm;
		run(6'h25, 2'h0, 4'h1, 4'hE);
		rd(2'h0, 4'h1, 4'hE);
		for (int i = 0; i < 13; i++) begin
			run(iop[i], 2'h0, 4'h1, iimm[i]);
			cmp_bit(carry_o, icy[12-i]);
			cmp_bit(skip_o, isk[12-i]);
		end
		rd(2'h0, 4'h1, 4'hF);
	endtask

	task automatic t_gr;
		run(6'h25, 2'h0, 4'h5, 4'h7);
		run(6'h25, 2'h1, 4'h2, 4'hA);
		for (int i = 0; i < 11; i++) begin
			run(gop[i], 2'h1, 4'h2, 4'h5);
			cmp_bit(carry_o, gcy[10-i]);
			cmp_bit(skip_o, gsk[10-i]);
		end
		rd(2'h0, 4'h5, 4'hE);
	endtask

	task automatic t_xfer;
		run(6'h25, 2'h2, 4'h3, 4'h5);
		run(6'h20, 2'h2, 4'h3, 4'h9);
		rd(2'h0, 4'h9, 4'h5);
		run(6'h21, 2'h1, 4'h0, 4'h9);
		rd(2'h1, 4'h0, 4'h5);
		run(6'h24, 2'h1, 4'h4, 4'h0);
		rd(2'h1, 4'h4, 4'h5);
		run(6'h22, 2'h1, 4'h2, 4'h9);
		rd(2'h1, 4'h5, 4'hA);
		run(6'h23, 2'h1, 4'h6, 4'h9);
		rd(2'h1, 4'h6, 4'hA);
		row_pointer_i = 3'h5;
		run(6'h26, 2'h0, 4'h1, 4'h9);
		run(6'h27, 2'h3, 4'h7, 4'h9);
		rd(2'h3, 4'h7, 4'hF);
	endtask

	// every port group both ways; the input value must land in memory
	task automatic t_port;
		for (int g = 0; g < 6; g++) begin
			port_in_i = 4'(g + 6);
			run(6'h28 + 6'(g), 2'h3, 4'h8, {1'b0, 3'(g)});
			cmp_bit(port_dir_out_o, 1'b0);
			cmp_nib({1'b0, port_group_o}, 4'(g));
			run(6'h28 + 6'(g), 2'h3, 4'h8, {1'b1, 3'(7 - g)});
			cmp_bit(port_req_o, 1'b1);
			cmp_nib({1'b0, port_code_o}, 4'(7 - g));
			cmp_nib(port_data_o, 4'(g + 6));
		end
	endtask

	task automatic t_reset;
		run(6'h00, 2'h0, 4'h1, 4'h1);
		cmp_bit(carry_o, 1'b1);
		rst_i = 1'b1;
		@(negedge clock_i);
		rst_i = 1'b0;
		cmp_bit(carry_o, 1'b0);
		cmp_bit(port_req_o, 1'b0);
		// first instruction after a mid-run reset, then an undecoded code
		run(6'h03, 2'h0, 4'h1, 4'h2);
		cmp_bit(carry_o, 1'b1);
		cmp_bit(skip_o, 1'b0);
		run(6'h0E, 2'h0, 4'h1, 4'h1);
		cmp_bit(skip_o, 1'b0);
		cmp_bit(carry_o, 1'b0);
		rd(2'h0, 4'h1, 4'hE);
	endtask

	task automatic complete_run;
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		repeat (2) @(negedge clock_i);
		rst_i = 1'b0;
		cmp_bit(skip_o, 1'b0);
		t_imm();
		t_gr();
		t_xfer();
		for (int v = 4; v < 7; v++) cmps(6'h30, 4'(v), 4'h5, 4'(v));
		cmps(6'h34, 4'h5, 4'hE, 4'h5);
		cmps(6'h34, 4'h9, 4'h5, 4'h5);
		t_port();
		t_reset();
		complete_run();
	end
endmodule // test_mcu4_alu_transfer_io_decode
